// ===== shared/prtc_defines.vh
/*
 Register map, field positions, reset values and divider table
 of the periodic real-time counter. Definitions only.
 Assumes inclusion by bare name from the logic files.
*/
`ifndef PRTC_DEFINES_VH
`define PRTC_DEFINES_VH

// Byte offsets on the APB
`define PRTC_OFS_SC 8'h00
`define PRTC_OFS_CNT 8'h04
`define PRTC_OFS_MOD 8'h08
`define PRTC_OFS_IST 8'h0C
`define PRTC_OFS_IMSK 8'h10

// Fields of rtc_status_control
`define PRTC_SC_FLAG 7
`define PRTC_SC_SRC_HI 6
`define PRTC_SC_SRC_LO 5
`define PRTC_SC_IEN 4
`define PRTC_SC_PS_HI 3
`define PRTC_SC_PS_LO 0

// Fields of the event status and mask registers
`define PRTC_EV_MATCH 0
`define PRTC_EV_CFGCLR 1
`define PRTC_EV_W 2

// Reset values
`define PRTC_RST_SRC 2'h0
`define PRTC_RST_PS 4'h0
`define PRTC_RST_BYTE 8'h00
`define PRTC_RST_EV 2'h0
`define PRTC_RST_DIV 18'h0_0000

// Source select codes and prescaler-off code
`define PRTC_SRC_LOWPWR 2'h0
`define PRTC_SRC_EXT 2'h1
`define PRTC_PS_OFF 4'h0

// Divide-by values, source select low bit zero
`define PRTC_DIV_L1 18'd8
`define PRTC_DIV_L2 18'd32
`define PRTC_DIV_L3 18'd64
`define PRTC_DIV_L4 18'd128
`define PRTC_DIV_L5 18'd256
`define PRTC_DIV_L6 18'd512
`define PRTC_DIV_L7 18'd1024
`define PRTC_DIV_L8 18'd1
`define PRTC_DIV_L9 18'd2
`define PRTC_DIV_L10 18'd4
`define PRTC_DIV_L11 18'd10
`define PRTC_DIV_L12 18'd16
`define PRTC_DIV_L13 18'd100
`define PRTC_DIV_L14 18'd500
`define PRTC_DIV_L15 18'd1000

// Divide-by values, source select low bit one
`define PRTC_DIV_H1 18'd1024
`define PRTC_DIV_H2 18'd2048
`define PRTC_DIV_H3 18'd4096
`define PRTC_DIV_H4 18'd8192
`define PRTC_DIV_H5 18'd16384
`define PRTC_DIV_H6 18'd32768
`define PRTC_DIV_H7 18'd65536
`define PRTC_DIV_H8 18'd1000
`define PRTC_DIV_H9 18'd2000
`define PRTC_DIV_H10 18'd5000
`define PRTC_DIV_H11 18'd10000
`define PRTC_DIV_H12 18'd20000
`define PRTC_DIV_H13 18'd50000
`define PRTC_DIV_H14 18'd100000
`define PRTC_DIV_H15 18'd200000

`define PRTC_DIV_W 18
`define PRTC_NSRC 3

`endif

// ===== logic/prtc_top.v
/*
 Periodic real-time counter: APB register slave, clock source
 select, binary/decimal prescaler, 8-bit modulo up-counter,
 match flag and level interrupt.
 Assumes the three slow source clocks arrive as plain levels,
 much slower than CLK_I, and a zero-wait APB master.
*/
`timescale 1ns/100ps
`include "prtc_defines.vh"
`default_nettype none

module prtc_top #(
	parameter ADDR_W = 8
) (
	input wire CLK_I,
	input wire RESET_N_I,
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [ADDR_W-1:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	output wire PREADY_O,
	output reg [31:0] PRDATA_O,
	output reg PSLVERR_O,
	input wire LOW_POWER_OSC_CLOCK_I,
	input wire EXT_CLK_I,
	input wire INT_CLK_I,
	input wire DEBUG_HALT_I,
	input wire STOP2_I,
	input wire STOP3_I,
	output wire IRQ_O
);

	reg [1:0] source_select_ff;
	reg [3:0] divider_select_ff;
	reg match_irq_enable_ff;
	reg match_flag_ff;
	reg [7:0] count_ff;
	reg [7:0] limit_ff;
	reg [`PRTC_DIV_W-1:0] pre_ff;
	reg [`PRTC_EV_W-1:0] ev_stat_ff;
	reg [`PRTC_EV_W-1:0] ev_mask_ff;

	reg [1:0] nxt_source_select;
	reg [3:0] nxt_divider_select;
	reg nxt_match_irq_enable;
	reg nxt_match_flag;
	reg [7:0] nxt_count;
	reg [7:0] nxt_limit;
	reg [`PRTC_DIV_W-1:0] nxt_pre;
	reg [`PRTC_EV_W-1:0] nxt_ev_stat;
	reg [`PRTC_EV_W-1:0] nxt_ev_mask;
	reg [31:0] nxt_rdata;
	reg nxt_slverr;

	wire [`PRTC_NSRC-1:0] src_raw;
	wire [`PRTC_NSRC-1:0] src_edge;
	wire [ADDR_W-1:0] addr_sc;
	wire [ADDR_W-1:0] addr_cnt;
	wire [ADDR_W-1:0] addr_mod;
	wire [ADDR_W-1:0] addr_ist;
	wire [ADDR_W-1:0] addr_imsk;
	wire setup_ph;
	wire wr_en;
	wire wr_sc;
	wire wr_mod;
	wire wr_ist;
	wire wr_imsk;
	wire mapped;
	wire [1:0] wr_src;
	wire [3:0] wr_ps;
	wire cfg_clear;
	wire src_ok;
	wire sel_edge;
	wire run;
	wire [`PRTC_DIV_W-1:0] div_val;
	wire pre_last;
	wire tick;
	wire wrap;
	wire [7:0] sc_rd;
	wire irq_match;
	wire irq_event;

	assign src_raw = {INT_CLK_I, EXT_CLK_I, LOW_POWER_OSC_CLOCK_I};

	// Synchroniser per source; edge taken from stages two and three only
	genvar gi;
	generate
		for (gi = 0; gi < `PRTC_NSRC; gi = gi + 1) begin : g_sync
			reg s1_ff;
			reg s2_ff;
			reg s3_ff;
			always @(posedge CLK_I or negedge RESET_N_I) begin
				if (!RESET_N_I) begin
					s1_ff <= 1'b0;
					s2_ff <= 1'b0;
					s3_ff <= 1'b0;
				end else begin
					s1_ff <= src_raw[gi];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
				end
			end
			assign src_edge[gi] = s2_ff & ~s3_ff;
		end
	endgenerate

	// Divide-by lookup on the source low bit and prescaler code
	function [`PRTC_DIV_W-1:0] div_of;
		input hi;
		input [3:0] ps;
		begin
			div_of = `PRTC_RST_DIV;
			if (!hi) begin
				case (ps)
					4'h1: div_of = `PRTC_DIV_L1;
					4'h2: div_of = `PRTC_DIV_L2;
					4'h3: div_of = `PRTC_DIV_L3;
					4'h4: div_of = `PRTC_DIV_L4;
					4'h5: div_of = `PRTC_DIV_L5;
					4'h6: div_of = `PRTC_DIV_L6;
					4'h7: div_of = `PRTC_DIV_L7;
					4'h8: div_of = `PRTC_DIV_L8;
					4'h9: div_of = `PRTC_DIV_L9;
					4'hA: div_of = `PRTC_DIV_L10;
					4'hB: div_of = `PRTC_DIV_L11;
					4'hC: div_of = `PRTC_DIV_L12;
					4'hD: div_of = `PRTC_DIV_L13;
					4'hE: div_of = `PRTC_DIV_L14;
					4'hF: div_of = `PRTC_DIV_L15;
					default: div_of = `PRTC_RST_DIV;
				endcase
			end else begin
				case (ps)
					4'h1: div_of = `PRTC_DIV_H1;
					4'h2: div_of = `PRTC_DIV_H2;
					4'h3: div_of = `PRTC_DIV_H3;
					4'h4: div_of = `PRTC_DIV_H4;
					4'h5: div_of = `PRTC_DIV_H5;
					4'h6: div_of = `PRTC_DIV_H6;
					4'h7: div_of = `PRTC_DIV_H7;
					4'h8: div_of = `PRTC_DIV_H8;
					4'h9: div_of = `PRTC_DIV_H9;
					4'hA: div_of = `PRTC_DIV_H10;
					4'hB: div_of = `PRTC_DIV_H11;
					4'hC: div_of = `PRTC_DIV_H12;
					4'hD: div_of = `PRTC_DIV_H13;
					4'hE: div_of = `PRTC_DIV_H14;
					4'hF: div_of = `PRTC_DIV_H15;
					default: div_of = `PRTC_RST_DIV;
				endcase
			end
		end
	endfunction

	// APB decode
	assign addr_sc = `PRTC_OFS_SC;
	assign addr_cnt = `PRTC_OFS_CNT;
	assign addr_mod = `PRTC_OFS_MOD;
	assign addr_ist = `PRTC_OFS_IST;
	assign addr_imsk = `PRTC_OFS_IMSK;
	assign PREADY_O = 1'b1;
	assign setup_ph = PSEL_I & ~PENABLE_I;
	assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
	assign mapped = (PADDR_I == addr_sc) | (PADDR_I == addr_cnt) |
		(PADDR_I == addr_mod) | (PADDR_I == addr_ist) |
		(PADDR_I == addr_imsk);
	assign wr_sc = wr_en & (PADDR_I == addr_sc);
	assign wr_mod = wr_en & (PADDR_I == addr_mod);
	assign wr_ist = wr_en & (PADDR_I == addr_ist);
	assign wr_imsk = wr_en & (PADDR_I == addr_imsk);
	assign wr_src = PWDATA_I[`PRTC_SC_SRC_HI:`PRTC_SC_SRC_LO];
	assign wr_ps = PWDATA_I[`PRTC_SC_PS_HI:`PRTC_SC_PS_LO];

	// A changed source or prescaler clears, as does any modulo write; rewriting the same selection keeps counting
	assign cfg_clear = (wr_sc & (wr_src != source_select_ff)) |
		(wr_sc & (wr_ps != divider_select_ff)) |
		wr_mod;

	// Source mux: 00 low-power osc, 01 external, 1x internal
	assign sel_edge = (source_select_ff == `PRTC_SRC_LOWPWR) ? src_edge[0] :
		(source_select_ff == `PRTC_SRC_EXT) ? src_edge[1] :
		src_edge[2];

	// Stop2 leaves only the low-power osc alive; stop3 keeps every source
	assign src_ok = ~STOP2_I | STOP3_I |
		(source_select_ff == `PRTC_SRC_LOWPWR);

	assign run = (divider_select_ff != `PRTC_PS_OFF) &
		~DEBUG_HALT_I & src_ok;

	assign div_val = div_of(source_select_ff[0], divider_select_ff);
	assign pre_last = (pre_ff == (div_val - 1'b1));
	assign tick = run & sel_edge & pre_last;
	assign wrap = tick & (count_ff == limit_ff);

	assign sc_rd = {match_flag_ff, source_select_ff,
		match_irq_enable_ff, divider_select_ff};

	// Software-owned configuration
	always @* begin
		nxt_source_select = source_select_ff;
		nxt_divider_select = divider_select_ff;
		nxt_match_irq_enable = match_irq_enable_ff;
		nxt_limit = limit_ff;
		nxt_ev_mask = ev_mask_ff;
		if (wr_sc) begin
			nxt_source_select = wr_src;
			nxt_divider_select = wr_ps;
			nxt_match_irq_enable = PWDATA_I[`PRTC_SC_IEN];
		end
		if (wr_mod) begin
			nxt_limit = PWDATA_I[7:0];
		end
		if (wr_imsk) begin
			nxt_ev_mask = PWDATA_I[`PRTC_EV_W-1:0];
		end
	end

	// Frozen state holds while halted, so counting resumes in place
	always @* begin
		nxt_pre = pre_ff;
		nxt_count = count_ff;
		if (cfg_clear) begin
			nxt_pre = `PRTC_RST_DIV;
			nxt_count = `PRTC_RST_BYTE;
		end else if (run & sel_edge) begin
			if (pre_last) begin
				nxt_pre = `PRTC_RST_DIV;
				if (count_ff == limit_ff) begin
					nxt_count = `PRTC_RST_BYTE;
				end else begin
					nxt_count = count_ff + 8'h01;
				end
			end else begin
				nxt_pre = pre_ff + 1'b1;
			end
		end
	end

	// Set wins over a clear in the same cycle
	always @* begin
		nxt_match_flag = match_flag_ff;
		if (wr_sc & PWDATA_I[`PRTC_SC_FLAG]) begin
			nxt_match_flag = 1'b0;
		end
		if (wrap) begin
			nxt_match_flag = 1'b1;
		end
	end

	// Event bits follow the same set-over-clear priority
	always @* begin
		nxt_ev_stat = ev_stat_ff;
		if (wr_ist) begin
			nxt_ev_stat = ev_stat_ff & ~PWDATA_I[`PRTC_EV_W-1:0];
		end
		if (wrap) begin
			nxt_ev_stat[`PRTC_EV_MATCH] = 1'b1;
		end
		if (cfg_clear) begin
			nxt_ev_stat[`PRTC_EV_CFGCLR] = 1'b1;
		end
	end

	// Read data captured in the setup phase, stable through the access phase
	always @* begin
		nxt_rdata = PRDATA_O;
		nxt_slverr = PSLVERR_O;
		if (setup_ph) begin
			nxt_slverr = ~mapped;
			nxt_rdata = 32'h0000_0000;
			if (!PWRITE_I) begin
				// Unmapped reads return zero alongside the error
				case (PADDR_I)
					addr_sc: begin
						nxt_rdata[7:0] = sc_rd;
					end
					addr_cnt: begin
						nxt_rdata[7:0] = count_ff;
					end
					addr_mod: begin
						nxt_rdata[7:0] = limit_ff;
					end
					addr_ist: begin
						nxt_rdata[`PRTC_EV_W-1:0] = ev_stat_ff;
					end
					addr_imsk: begin
						nxt_rdata[`PRTC_EV_W-1:0] = ev_mask_ff;
					end
					default: begin
						nxt_rdata = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// Configuration and limit
	always @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			source_select_ff <= `PRTC_RST_SRC;
			divider_select_ff <= `PRTC_RST_PS;
			match_irq_enable_ff <= 1'b0;
			limit_ff <= `PRTC_RST_BYTE;
			ev_mask_ff <= `PRTC_RST_EV;
		end else begin
			source_select_ff <= nxt_source_select;
			divider_select_ff <= nxt_divider_select;
			match_irq_enable_ff <= nxt_match_irq_enable;
			limit_ff <= nxt_limit;
			ev_mask_ff <= nxt_ev_mask;
		end
	end

	// Counting state and sticky flags
	always @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			match_flag_ff <= 1'b0;
			count_ff <= `PRTC_RST_BYTE;
			pre_ff <= `PRTC_RST_DIV;
			ev_stat_ff <= `PRTC_RST_EV;
		end else begin
			match_flag_ff <= nxt_match_flag;
			count_ff <= nxt_count;
			pre_ff <= nxt_pre;
			ev_stat_ff <= nxt_ev_stat;
		end
	end

	// Bus answer registers
	always @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			PRDATA_O <= 32'h0000_0000;
			PSLVERR_O <= 1'b0;
		end else begin
			PRDATA_O <= nxt_rdata;
			PSLVERR_O <= nxt_slverr;
		end
	end

	// Match request and event request share one level output
	assign irq_match = match_flag_ff & match_irq_enable_ff;
	assign irq_event = |(ev_stat_ff & ev_mask_ff);
	assign IRQ_O = irq_match | irq_event;

endmodule
`default_nettype wire

// ===== tb/prtc_monitor.sv
/*
 Port-level assertions for prtc_top.
 Assumes binding to prtc_top and a plain APB master in front of it.
*/
`timescale 1ns/100ps
`default_nettype none
module prtc_monitor #(
	parameter ADDR_W = 8
) (
	input wire CLK_I,
	input wire RESET_N_I,
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [ADDR_W-1:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	input wire PREADY_O,
	input wire [31:0] PRDATA_O,
	input wire PSLVERR_O,
	input wire LOW_POWER_OSC_CLOCK_I,
	input wire EXT_CLK_I,
	input wire INT_CLK_I,
	input wire DEBUG_HALT_I,
	input wire STOP2_I,
	input wire STOP3_I,
	input wire IRQ_O
);
	wire acc = PSEL_I && PENABLE_I;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESET_N_I);
	AST_READY: assert property (PREADY_O) else $error("ready low");
	AST_RST_QUIET: assert property (!$past(RESET_N_I) |-> !IRQ_O && !PSLVERR_O)
		else $error("outputs active after reset");
	AST_UNMAP_ERR: assert property (acc && PADDR_I > 8'h10 |-> PSLVERR_O)
		else $error("unmapped access without error");
	AST_MAPPED_OK: assert property (acc && PADDR_I <= 8'h10 && PADDR_I[1:0] == 2'h0 |-> !PSLVERR_O)
		else $error("mapped access flagged");
	AST_RDATA: assert property (acc && !PWRITE_I |->
		PRDATA_O[31:8] == 24'h00_0000 && (PADDR_I <= 8'h10 || PRDATA_O[7:0] == 8'h00))
		else $error("read data upper bits set");
	AST_CNT_WR: assert property (acc && PWRITE_I && PADDR_I == 8'h04 |-> !PSLVERR_O)
		else $error("count write flagged");
	AST_HALT: assert property ($past(DEBUG_HALT_I) && $past(DEBUG_HALT_I, 2)
		&& !$past(acc && PWRITE_I) |-> !$rose(IRQ_O)) else $error("irq rose while halted");
	AST_IRQ_STICKY: assert property ($fell(IRQ_O) |-> $past(acc && PWRITE_I))
		else $error("irq fell without write");
endmodule
`default_nettype wire

// ===== tb/tb_periodic_realtime_counter.sv
/*
 Testbench for prtc_top: APB tasks and slow source pulses.
 Assumes a zero-wait slave and source levels of >= 2 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
`include "prtc_defines.vh"
module tb_periodic_realtime_counter;
	reg clk, rst_n, psel, pen, pwr, halt, stop2, stop3, bad;
	reg [7:0] paddr;
	reg [31:0] pwdata, rd;
	reg [2:0] srcs;
	wire pready, pslverr, irq;
	wire [31:0] prdata;
	int mismatches, compares;
	prtc_top #(.ADDR_W(8)) i_prtc_top (.CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
		.PRDATA_O(prdata), .PSLVERR_O(pslverr), .LOW_POWER_OSC_CLOCK_I(srcs[0]),
		.EXT_CLK_I(srcs[1]),
		.INT_CLK_I(srcs[2]), .DEBUG_HALT_I(halt), .STOP2_I(stop2), .STOP3_I(stop3), .IRQ_O(irq));
	task chk(input [31:0] got, input [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task xfer(input bit wr, input [7:0] a, input [7:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= wr;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) mismatches++;
		rd = prdata;
		bad = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task rdchk(input [7:0] a, input [31:0] e);
		xfer(0, a, 8'h00);
		chk(rd, e);
	endtask
	// Slow edges; trailing idle lets the synchroniser drain
	task pulse(input int s, input int n);
		repeat (n) begin
			srcs[s] <= 1'b1;
			repeat (2) @(posedge clk);
			srcs[s] <= 1'b0;
			repeat (2) @(posedge clk);
		end
		repeat (6) @(posedge clk);
	endtask
	task t_reset();
		rdchk(`PRTC_OFS_SC, 8'h00);
		rdchk(`PRTC_OFS_CNT, 8'h00);
		rdchk(`PRTC_OFS_MOD, 8'h00);
		xfer(0, 8'h20, 8'h00);
		chk(bad, 1'b1);
	endtask
	task t_wrap();
		xfer(1, `PRTC_OFS_MOD, 8'h02);
		xfer(1, `PRTC_OFS_SC, 8'h18);
		pulse(0, 2);
		rdchk(`PRTC_OFS_CNT, 8'h02);
		pulse(0, 1);
		rdchk(`PRTC_OFS_CNT, 8'h00);
		rdchk(`PRTC_OFS_SC, 8'h98);
		chk(irq, 1'b1);
		xfer(1, `PRTC_OFS_CNT, 8'h55);
		rdchk(`PRTC_OFS_CNT, 8'h00);
		xfer(1, `PRTC_OFS_SC, 8'h18);
		rdchk(`PRTC_OFS_SC, 8'h98);
		xfer(1, `PRTC_OFS_SC, 8'h98);
		rdchk(`PRTC_OFS_SC, 8'h18);
		chk(irq, 1'b0);
		pulse(0, 3);
		xfer(1, `PRTC_OFS_SC, 8'h08);
		@(posedge clk);
		chk(irq, 1'b0);
	endtask
	task t_div();
		xfer(1, `PRTC_OFS_SC, 8'h01);
		pulse(0, 7);
		rdchk(`PRTC_OFS_CNT, 8'h00);
		pulse(0, 1);
		rdchk(`PRTC_OFS_CNT, 8'h01);
		xfer(1, `PRTC_OFS_SC, 8'h02);
		rdchk(`PRTC_OFS_CNT, 8'h00);
		xfer(1, `PRTC_OFS_SC, 8'h28);
		pulse(1, 999);
		rdchk(`PRTC_OFS_CNT, 8'h00);
		pulse(1, 1);
		rdchk(`PRTC_OFS_CNT, 8'h01);
	endtask
	task t_src();
		xfer(1, `PRTC_OFS_SC, 8'h48);
		pulse(0, 1);
		pulse(1, 1);
		rdchk(`PRTC_OFS_CNT, 8'h00);
		pulse(2, 1);
		rdchk(`PRTC_OFS_CNT, 8'h01);
		xfer(1, `PRTC_OFS_SC, 8'h08);
		rdchk(`PRTC_OFS_CNT, 8'h00);
		xfer(1, `PRTC_OFS_SC, 8'h68);
		pulse(2, 999);
		rdchk(`PRTC_OFS_CNT, 8'h00);
		pulse(2, 1);
		rdchk(`PRTC_OFS_CNT, 8'h01);
	endtask
	task t_mod();
		xfer(1, `PRTC_OFS_SC, 8'h88);
		xfer(1, `PRTC_OFS_MOD, 8'h00);
		pulse(0, 1);
		rdchk(`PRTC_OFS_SC, 8'h88);
		xfer(1, `PRTC_OFS_MOD, 8'h05);
		pulse(0, 3);
		rdchk(`PRTC_OFS_CNT, 8'h03);
		xfer(1, `PRTC_OFS_MOD, 8'h05);
		rdchk(`PRTC_OFS_CNT, 8'h00);
		rdchk(`PRTC_OFS_MOD, 8'h05);
	endtask
	task t_halt();
		pulse(0, 2);
		halt <= 1'b1;
		pulse(0, 2);
		rdchk(`PRTC_OFS_CNT, 8'h02);
		halt <= 1'b0;
		pulse(0, 1);
		rdchk(`PRTC_OFS_CNT, 8'h03);
	endtask
	task t_stop();
		xfer(1, `PRTC_OFS_SC, 8'h48);
		stop2 <= 1'b1;
		pulse(2, 2);
		rdchk(`PRTC_OFS_CNT, 8'h00);
		stop3 <= 1'b1;
		pulse(2, 1);
		rdchk(`PRTC_OFS_CNT, 8'h01);
		xfer(1, `PRTC_OFS_SC, 8'h08);
		stop3 <= 1'b0;
		pulse(0, 1);
		rdchk(`PRTC_OFS_CNT, 8'h01);
		stop2 <= 1'b0;
		xfer(1, `PRTC_OFS_SC, 8'h00);
		pulse(0, 2);
		rdchk(`PRTC_OFS_CNT, 8'h00);
	endtask
	task t_ev();
		xfer(1, `PRTC_OFS_IMSK, 8'h01);
		rdchk(`PRTC_OFS_IMSK, 8'h01);
		rdchk(`PRTC_OFS_IST, 8'h03);
		chk(irq, 1'b1);
		xfer(1, `PRTC_OFS_IST, 8'h03);
		rdchk(`PRTC_OFS_IST, 8'h00);
		chk(irq, 1'b0);
	endtask
	task print_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Whole run is about 8.4k cycles; 40k gives margin
	initial begin
		#800000;
		mismatches++;
		print_verdict();
	end
	initial begin
		{rst_n, psel, pen, pwr, halt, stop2, stop3, bad} = 8'h00;
		{paddr, pwdata, srcs} = 43'h0;
		mismatches = 0;
		compares = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_wrap();
		t_div();
		t_src();
		t_mod();
		t_halt();
		t_stop();
		t_ev();
		print_verdict();
	end
endmodule
bind prtc_top prtc_monitor #(.ADDR_W(ADDR_W)) i_prtc_monitor (.CLK_I(CLK_I),
	.RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
	.PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O), .PRDATA_O(PRDATA_O),
	.PSLVERR_O(PSLVERR_O), .LOW_POWER_OSC_CLOCK_I(LOW_POWER_OSC_CLOCK_I),
	.EXT_CLK_I(EXT_CLK_I), .INT_CLK_I(INT_CLK_I),
	.DEBUG_HALT_I(DEBUG_HALT_I), .STOP2_I(STOP2_I), .STOP3_I(STOP3_I), .IRQ_O(IRQ_O));
`default_nettype wire
